// [gpc_capture.sv]
`timescale 1ns/100ps
`default_nettype none
`include "gpc_regs.svh"
// ==========================================================
// game port capture: per-channel analog timing or digital sampling
module gpc_capture #(
    parameter int FRAME_CYCLES = `GPC_FRAME_CYCLES,
    parameter int DISCH_CYCLES = `GPC_DISCHARGE_CYC
) (
    // clocking
    input  wire logic                         clk_sys,
    input  wire logic                         reset_n,
    input  wire logic                         clk_en,
    // pins
    input  wire logic [7:0]                   channel_pins_in,
    output logic      [7:0]                   channel_pins_out,
    output logic      [7:0]                   channel_pins_oe,
    input  wire logic                         timing_cap_trip,
    output logic                              timing_cap_pos,
    output logic                              timing_cap_neg,
    // high-precision read port
    input  wire logic [2:0]                   hp_sel,
    output gpc_pkg::gpc_result_t              hp_result,
    output logic      [7:0]                   analog_map,
    // legacy port byte
    input  wire logic                         legacy_fire,
    output logic      [7:0]                   legacy_byte,
    output logic                              frame_done
);
    localparam logic [12:0] CMAX = `GPC_COUNT_MAX;

    logic [7:0] pins_s;
    logic [7:0] trip_s;

    // synchronise channel pins and comparator
    gpc_sync #(.WIDTH(8)) u_sync_pins (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .async_in (channel_pins_in),
        .sync_out (pins_s)
    );
    gpc_sync #(.WIDTH(8)) u_sync_trip (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .clk_en   (clk_en),
        .async_in ({7'h00, timing_cap_trip}),
        .sync_out (trip_s)
    );

    // ======================================================
    // sequencer state
    gpc_pkg::gpc_state_t state;
    gpc_pkg::gpc_state_t next_state;
    logic [2:0]  chan;
    logic [2:0]  next_chan;
    logic [12:0] cnt;
    logic [12:0] next_cnt;
    logic [31:0] frame_cnt;
    logic [31:0] next_frame_cnt;
    logic [12:0] value   [8];
    logic [7:0]  is_analog;
    logic [7:0]  next_is_analog;
    logic        store_en;
    logic        frame_tick;

    // frame timer starts one sweep per frame
    always_comb
    begin
        frame_tick     = (frame_cnt == 32'(FRAME_CYCLES - 1));
        next_frame_cnt = frame_tick ? 32'h0000_0000 : frame_cnt + 32'h0000_0001;
    end

    // sweep every channel: discharge, count, store
    always_comb
    begin
        next_state     = state;
        next_chan      = chan;
        next_cnt       = cnt;
        next_is_analog = is_analog;
        store_en       = 1'b0;
        case (state)
            gpc_pkg::GPC_ST_IDLE:
            begin
                if (frame_tick)
                begin
                    next_chan  = 3'h0;
                    next_cnt   = 13'h0000;
                    next_state = gpc_pkg::GPC_ST_DISCHARGE;
                end
            end
            gpc_pkg::GPC_ST_DISCHARGE:
            begin
                if (cnt == 13'(DISCH_CYCLES - 1))
                begin
                    next_cnt   = 13'h0000;
                    next_state = gpc_pkg::GPC_ST_COUNT;
                end
                else
                    next_cnt = cnt + 13'h0001;
            end
            gpc_pkg::GPC_ST_COUNT:
            begin
                // saturation means no pot: the channel is digital
                if (trip_s[0] || cnt == CMAX)
                    next_state = gpc_pkg::GPC_ST_STORE;
                else
                    next_cnt = cnt + 13'h0001;
            end
            gpc_pkg::GPC_ST_STORE:
            begin
                store_en             = 1'b1;
                next_is_analog[chan] = (cnt != CMAX);
                next_cnt             = 13'h0000;
                next_chan            = chan + 3'h1;
                next_state = (chan == 3'h7) ? gpc_pkg::GPC_ST_IDLE
                                            : gpc_pkg::GPC_ST_DISCHARGE;
            end
            default:
                next_state = gpc_pkg::GPC_ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            state     <= gpc_pkg::GPC_ST_IDLE;
            chan      <= 3'h0;
            cnt       <= 13'h0000;
            frame_cnt <= 32'h0000_0000;
            is_analog <= 8'h00;
        end
        else if (clk_en)
        begin
            state     <= next_state;
            chan      <= next_chan;
            cnt       <= next_cnt;
            frame_cnt <= next_frame_cnt;
            is_analog <= next_is_analog;
        end
    end

    // per-channel result registers, saturated count
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_val
            always_ff @(posedge clk_sys)
            begin
                if (!reset_n)
                    value[g] <= 13'h0000;
                else if (clk_en && store_en && chan == 3'(g))
                    value[g] <= cnt;
            end
        end
    endgenerate

    // ======================================================
    // pin drive: discharge pulls the selected pin low
    always_comb
    begin
        channel_pins_out = 8'h00;
        channel_pins_oe  = 8'hFF;
        if (state == gpc_pkg::GPC_ST_DISCHARGE)
            channel_pins_oe[chan] = 1'b0;
    end
    assign timing_cap_neg = (state == gpc_pkg::GPC_ST_DISCHARGE);
    assign timing_cap_pos = (state == gpc_pkg::GPC_ST_COUNT);

    // ======================================================
    // read paths: high-precision and legacy
    gpc_pkg::gpc_result_t next_hp;
    logic [7:0]           next_legacy;
    logic [7:0]           legacy_timing;

    // legacy byte: axis bits high while timing after a fire write
    always_comb
    begin
        next_hp.is_analog = is_analog[hp_sel];
        next_hp.pressed   = ~pins_s[hp_sel];
        next_hp.value     = {3'h0, value[hp_sel]};
        next_legacy       = {pins_s[7:4], legacy_timing[3:0]};
    end

    logic [12:0] leg_cnt;
    logic [12:0] next_leg_cnt;
    always_comb
    begin
        next_leg_cnt = legacy_fire ? 13'h0000
                     : (leg_cnt == CMAX ? CMAX : leg_cnt + 13'h0001);
        for (int i = 0; i < 4; i++)
            legacy_timing[i] = is_analog[i] && (leg_cnt < value[i]);
        legacy_timing[7:4] = 4'h0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            hp_result   <= '0;
            legacy_byte <= 8'hF0;
            leg_cnt     <= CMAX;
            frame_done  <= 1'b0;
        end
        else if (clk_en)
        begin
            hp_result   <= next_hp;
            legacy_byte <= next_legacy;
            leg_cnt     <= next_leg_cnt;
            frame_done  <= store_en && chan == 3'h7;
        end
    end
    assign analog_map = is_analog;

    // ======================================================
    // checks
    // a count that reaches the top stops there and is stored as it stands
    property p_sat;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && state == gpc_pkg::GPC_ST_COUNT && cnt == CMAX)
            |=> state == gpc_pkg::GPC_ST_STORE && cnt == CMAX;
    endproperty
    a_sat: assert property (p_sat) else $error("count beyond 13 bits");

    property p_upper;
        @(posedge clk_sys) disable iff (!reset_n)
        hp_result.value[15:13] == 3'h0;
    endproperty
    a_upper: assert property (p_upper) else $error("upper bits not zero");

    property p_class;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && state == gpc_pkg::GPC_ST_STORE)
            |=> is_analog[$past(chan)] == ($past(cnt) != CMAX);
    endproperty
    a_class: assert property (p_class) else $error("wrong classification");

    property p_disch;
        @(posedge clk_sys) disable iff (!reset_n)
        state == gpc_pkg::GPC_ST_DISCHARGE |-> !channel_pins_oe[chan] && timing_cap_neg;
    endproperty
    a_disch: assert property (p_disch) else $error("pin not driven in discharge");

    property p_next;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && state == gpc_pkg::GPC_ST_STORE && chan != 3'h7)
            |=> state == gpc_pkg::GPC_ST_DISCHARGE && chan == $past(chan) + 3'h1;
    endproperty
    a_next: assert property (p_next) else $error("sweep skipped a channel");

    property p_frame;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && frame_tick && state == gpc_pkg::GPC_ST_IDLE)
            |=> state == gpc_pkg::GPC_ST_DISCHARGE && chan == 3'h0;
    endproperty
    a_frame: assert property (p_frame) else $error("frame did not start sweep");

    property p_press;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> hp_result.pressed == !$past(pins_s[hp_sel]);
    endproperty
    a_press: assert property (p_press) else $error("pressed state wrong");

    property p_count;
        @(posedge clk_sys) disable iff (!reset_n)
        (clk_en && state == gpc_pkg::GPC_ST_COUNT && !trip_s[0] && cnt != CMAX)
            |=> cnt == $past(cnt) + 13'h0001;
    endproperty
    a_count: assert property (p_count) else $error("count did not advance");

    property p_legacy;
        @(posedge clk_sys) disable iff (!reset_n)
        clk_en |=> legacy_byte[7:4] == $past(pins_s[7:4]);
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy buttons wrong");

    c_store:  cover property (@(posedge clk_sys) state == gpc_pkg::GPC_ST_STORE);
    c_analog: cover property (@(posedge clk_sys) is_analog != 8'h00);
    c_done:   cover property (@(posedge clk_sys) frame_done);
endmodule
`default_nettype wire

// [gpc_pkg.sv]
// ==========================================================
// types shared by the capture logic
package gpc_pkg;
    typedef enum logic [1:0] {
        GPC_ST_IDLE      = 2'b00,
        GPC_ST_DISCHARGE = 2'b01,
        GPC_ST_COUNT     = 2'b10,
        GPC_ST_STORE     = 2'b11
    } gpc_state_t;

    typedef struct packed {
        logic        is_analog;
        logic        pressed;
        logic [15:0] value;
    } gpc_result_t;
endpackage

// [gpc_regs.svh]
// Notes on behaviour
// - each of eight channels analog or digital
// - no potentiometer means digital channel
// - legacy and high-precision paths both offered
// - legacy path mimics classic game port byte
// - all channel results refresh without polling
// - classification and value readable per channel
// - charge interval counted on system clock
// - 16-bit results, low 13 bits written
// - each channel captured once per frame
`ifndef GPC_REGS_SVH
`define GPC_REGS_SVH

`define GPC_NUM_CHANNELS   8
`define GPC_RESULT_WIDTH   16
`define GPC_COUNT_WIDTH    13
`define GPC_COUNT_MAX      13'h1FFF
`define GPC_XTAL_HZ        12096000
`define GPC_FRAME_HZ       90
`define GPC_CLK_HZ         40000000
// capture frame length in system clocks
`define GPC_FRAME_CYCLES   (`GPC_CLK_HZ / `GPC_FRAME_HZ)
// capacitor discharge time in microseconds and cycles
`define GPC_DISCHARGE_US   10
`define GPC_DISCHARGE_CYC  ((`GPC_DISCHARGE_US * `GPC_CLK_HZ + 999999) / 1000000)
`define GPC_LEGACY_ADDR    16'h0201
`define GPC_SEL_WIDTH      3

`endif

// [gpc_stick.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// controllers on the channel pins and the timing capacitor
module gpc_stick (
    // clocking
    input  wire logic             clk_sys,
    // device side
    input  wire logic [7:0]       pins_oe,
    input  wire logic [7:0]       pins_out,
    input  wire logic             cap_pos,
    output logic      [7:0]       pins_in,
    output logic                  cap_trip,
    // controller set-up
    input  wire logic [7:0]       analog,
    input  wire logic [7:0]       pressed,
    input  wire logic [7:0][12:0] charge_time
);
    logic [2:0]  chan = 3'h0;
    logic [13:0] cnt  = 14'h0;

    // follow the channel being discharged and time its charge
    always @(posedge clk_sys)
    begin
        for (int i = 0; i < 8; i++)
            if (!pins_oe[i])
                chan <= i[2:0];
        cnt <= cap_pos ? cnt + 14'h1 : 14'h0;
    end

    // pot holds analog pins high, a pressed switch shorts to ground, else pull-up
    always_comb
        for (int i = 0; i < 8; i++)
            pins_in[i] = !pins_oe[i] ? pins_out[i] : (analog[i] | !pressed[i]);

    // comparator trips once the pot has charged the capacitor; never without a pot
    assign cap_trip = cap_pos && analog[chan] && (cnt >= {1'b0, charge_time[chan]});
endmodule
`default_nettype wire

// [gpc_sync.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// two-flop synchroniser for pin levels
module gpc_sync #(
    parameter int WIDTH = 8
) (
    // clocking
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    input  wire logic             clk_en,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // first stage feeds only the second
    always_ff @(posedge clk_sys)
    begin
        if (!reset_n)
        begin
            stage1 <= '1;
            stage2 <= '1;
        end
        else if (clk_en)
        begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;
endmodule
`default_nettype wire

// [testbench.sv]
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// ==========================================================
// self-checking bench for the game port capture block
module testbench;
    logic                 clk_sys     = 1'b0;
    logic                 reset_n     = 1'b0;
    logic                 clk_en      = 1'b1;
    logic                 legacy_fire = 1'b0;
    logic [2:0]           hp_sel      = 3'h0;
    logic [7:0]           amask       = 8'hFF;
    logic [7:0]           pressed     = 8'h00;
    logic [7:0][12:0]     dly         = '0;
    logic [7:0]           pins_in;
    logic [7:0]           pins_out;
    logic [7:0]           pins_oe;
    logic [7:0]           analog_map;
    logic [7:0]           legacy_byte;
    logic                 trip;
    logic                 cap_pos;
    logic                 cap_neg;
    logic                 frame_done;
    gpc_pkg::gpc_result_t hp_result;
    integer               seed        = 32'h1A729814;
    int                   errors      = 0;
    int                   compares    = 0;

    // 40 MHz system clock
    always #12.5 clk_sys = ~clk_sys;

    // ==========================================================
    // design and far-side controllers
    gpc_capture #(.FRAME_CYCLES(22000), .DISCH_CYCLES(4)) DUT (
        .clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .channel_pins_in(pins_in), .channel_pins_out(pins_out), .channel_pins_oe(pins_oe),
        .timing_cap_trip(trip), .timing_cap_pos(cap_pos), .timing_cap_neg(cap_neg),
        .hp_sel(hp_sel), .hp_result(hp_result), .analog_map(analog_map),
        .legacy_fire(legacy_fire), .legacy_byte(legacy_byte), .frame_done(frame_done));

    gpc_stick stick (
        .clk_sys(clk_sys), .pins_oe(pins_oe), .pins_out(pins_out), .cap_pos(cap_pos),
        .pins_in(pins_in), .cap_trip(trip), .analog(amask), .pressed(pressed),
        .charge_time(dly));

    // ==========================================================
    // verdict and end of run
    task automatic wrap_up;
        begin
            $display("errors=%0d compares=%0d", errors, compares);
            if (errors == 0 && compares > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask

    // one or two random channels become switches, the rest pots with random charge times; a nonzero first fixes channel 0 at 1
    task automatic new_config(input int first);
        int d0;
        int d1;
        begin
            d0 = {$random(seed)} % 8;
            d1 = {$random(seed)} % 8;
            @(posedge clk_sys);
            for (int c = 0; c < 8; c++)
            begin
                amask[c]   <= (c != d0) && (c != d1);
                pressed[c] <= (c == d0 || c == d1) && ($random(seed) % 2 != 0);
                dly[c]     <= (first != 0 && c == 0) ? 13'h1 : 13'(1 + {$random(seed)} % 500);
            end
        end
    endtask

    // bounded wait for the end of a sweep
    task automatic wait_frame;
        int n;
        begin
            n = 0;
            @(negedge clk_sys);
            while (frame_done !== 1'b1 && n < 45000)
            begin
                `CHK(cap_neg, pins_oe != 8'hFF)
                @(negedge clk_sys);
                n++;
            end
            if (n >= 45000)
            begin
                errors++;
                wrap_up();
            end
        end
    endtask

    // read every channel and the legacy byte against the expected controllers
    task automatic check_frame;
        int v;
        begin
            `CHK(analog_map, amask)
            for (int c = 0; c < 8; c++)
            begin
                @(posedge clk_sys);
                hp_sel <= 3'(c);
                repeat (2) @(negedge clk_sys);
                v = int'(hp_result.value[12:0]);
                `CHK(hp_result.is_analog, amask[c])
                `CHK(hp_result.value[15:13], 3'h0)
                if (amask[c])
                    `CHK((v + 1 >= int'(dly[c])) && (v <= int'(dly[c]) + 5), 1'b1)
                else
                    `CHK(hp_result.value, 16'h1FFF)
                if (!amask[c])
                    `CHK(hp_result.pressed, pressed[c])
            end
            // a low clock enable freezes the read register
            @(posedge clk_sys);
            clk_en <= 1'b0;
            hp_sel <= 3'h0;
            repeat (3) @(negedge clk_sys);
            `CHK(hp_result.is_analog, amask[7])
            @(posedge clk_sys);
            clk_en <= 1'b1;
            repeat (2) @(negedge clk_sys);
            `CHK(hp_result.is_analog, amask[0])
            // legacy timing restarts on fire
            @(posedge clk_sys);
            legacy_fire <= 1'b1;
            @(posedge clk_sys);
            legacy_fire <= 1'b0;
            repeat (2) @(negedge clk_sys);
            for (int c = 0; c < 4; c++)
                if (amask[c] && dly[c] > 13'h14)
                    `CHK(legacy_byte[c], 1'b1)
            `CHK(legacy_byte[7:4], ~pressed[7:4])
            repeat (700) @(negedge clk_sys);
            `CHK(legacy_byte[3:0], 4'h0)
        end
    endtask

    // ==========================================================
    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK(pins_oe, 8'hFF)
        `CHK(hp_result, 18'h0)
        `CHK(analog_map, 8'h00)
        `CHK(legacy_byte, 8'hF0)
        @(posedge clk_sys);
        reset_n <= 1'b1;
        new_config(1);
        for (int f = 0; f < 3; f++)
        begin
            wait_frame();
            check_frame();
            new_config(0);
        end
        wrap_up();
    end
endmodule
`default_nettype wire
